// *** rlvd_top.sv ***
// Purpose: Reset-delay prescaler, low-voltage reset and warning units with AXI4-Lite registers
// Assumes: rst_n is the power-on reset; wdt_reset is a synchronous watchdog reset pulse
// Notes:   Comparator levels arrive asynchronously from the analog side
// Operation
// - Pin low holds prescaler and chip reset
// - Release internal reset after 131072 counted cycles
// - Reject reset pin pulses under 100 ns
// - Reset unit idles in standby after power-on
// - Low supply with enable: reset low, prescaler reset
// - Supply back: recount 131072 cycles then release
// - Low-voltage reset keeps power, level, enable bits
// - Warning unit idles in standby after power-on
// - Fall below warning: warn low, flag, irq
// - Rise above threshold: warn high, rise flag, irq
// - Below lower reset threshold performs reset action
// - Flags clear by writing zero after reading one
// - Control bits reset by power-on or watchdog only
`timescale 1ns/1ns
module rlvd_top import rlvd_pkg::*; #(
    parameter int unsigned DELAY_CYCLES = RLVD_DELAY_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       ext_reset_pin_n,
    input  wire logic       wdt_reset,
    input  wire rlvd_cmp_t  cmp_async,
    output logic            sys_reset_n,
    output logic            delay_count_done,
    output logic            volt_reset_n,
    output logic            volt_warn_n,
    output logic            external_irq_line0,
    output logic            detector_power_on,
    output logic            reset_level_select,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    output logic [1:0]      s_axi_bresp,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp
);
    typedef struct packed {
        rlvd_phase_t            phase;
        logic [RLVD_CNT_W-1:0]  count;
        logic                   sys_reset_n;
        logic                   done;
        logic                   volt_reset_n;
        logic                   volt_warn_n;
        logic                   irq;
        logic                   power_on;
        logic                   level_sel;
        logic                   reset_en;
        logic                   fall_en;
        logic                   rise_en;
        logic                   fall_flag;
        logic                   rise_flag;
        logic                   fall_seen;
        logic                   rise_seen;
        logic                   armed;
        logic                   prev_warn;
        logic                   prev_rise;
        logic                   aw_full;
        logic [RLVD_ADDR_W-1:0] awaddr;
        logic                   w_full;
        logic [7:0]             wdata;
        logic                   wlane;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
    } rlvd_state_t;

    localparam rlvd_state_t ST_RST = '{
        phase:   RLVD_PH_HOLD,
        volt_reset_n: 1'b1,
        volt_warn_n:  1'b1,
        power_on:  RLVD_CTRL_RST[RLVD_PWR_BIT],
        level_sel: RLVD_CTRL_RST[RLVD_SEL_BIT],
        reset_en:  RLVD_CTRL_RST[RLVD_RSTEN_BIT],
        fall_en:   RLVD_CTRL_RST[RLVD_FALLEN_BIT],
        rise_en:   RLVD_CTRL_RST[RLVD_RISEEN_BIT],
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        default: '0
    };

    rlvd_state_t s;
    rlvd_state_t next_s;
    rlvd_cmp_t   cmp_s;
    logic        pin_filt;
    logic        lv_trip;
    logic        wr_go;
    logic        wr_ctrl;
    logic        rd_go;
    logic [7:0]  ctrl_rd;
    logic [7:0]  stat_rd;

    rlvd_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (cmp_async),
        .sync_out (cmp_s)
    );

    rlvd_filter u_filter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .raw_n   (ext_reset_pin_n),
        .filt_n  (pin_filt)
    );

    always_comb begin
        ctrl_rd                  = 8'h00;
        ctrl_rd[RLVD_PWR_BIT]    = s.power_on;
        ctrl_rd[RLVD_SEL_BIT]    = s.level_sel;
        ctrl_rd[RLVD_RSTEN_BIT]  = s.reset_en;
        ctrl_rd[RLVD_FALLEN_BIT] = s.fall_en;
        ctrl_rd[RLVD_RISEEN_BIT] = s.rise_en;
        stat_rd                  = RLVD_STAT_RSVD;
        stat_rd[RLVD_FALL_BIT]   = s.fall_flag;
        stat_rd[RLVD_RISE_BIT]   = s.rise_flag;
    end

    assign lv_trip = s.power_on && s.reset_en && cmp_s.below_reset;
    assign wr_go   = s.aw_full && s.w_full && !s.bvalid;
    assign wr_ctrl = wr_go && s.wlane && s.awaddr == RLVD_CTRL_OFS;
    assign rd_go   = s_axi_arvalid && s.arready;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        next_s.irq  = 1'b0;

        // Write channel capture, either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.awaddr  = s_axi_awaddr[RLVD_ADDR_W-1:0];
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.wdata  = s_axi_wdata[7:0];
            next_s.wlane  = s_axi_wstrb[0];
        end
        if (s_axi_bready && s.bvalid) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RLVD_RESP_OKAY;
            unique case (s.awaddr)
                RLVD_CTRL_OFS: begin
                    if (s.wlane) begin
                        next_s.power_on  = s.wdata[RLVD_PWR_BIT];
                        next_s.level_sel = s.wdata[RLVD_SEL_BIT];
                        next_s.reset_en  = s.wdata[RLVD_RSTEN_BIT];
                        next_s.fall_en   = s.wdata[RLVD_FALLEN_BIT];
                        next_s.rise_en   = s.wdata[RLVD_RISEEN_BIT];
                    end
                end
                RLVD_STAT_OFS: begin
                    // Writing one has no effect; zero clears only after a read of one
                    if (s.wlane && !s.wdata[RLVD_FALL_BIT] && s.fall_seen) begin
                        next_s.fall_flag = 1'b0;
                        next_s.fall_seen = 1'b0;
                    end
                    if (s.wlane && !s.wdata[RLVD_RISE_BIT] && s.rise_seen) begin
                        next_s.rise_flag = 1'b0;
                        next_s.rise_seen = 1'b0;
                    end
                end
                RLVD_RSTS_OFS: begin
                end
                default: begin
                    next_s.bresp = RLVD_RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        if (s_axi_rready && s.rvalid) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RLVD_RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr[RLVD_ADDR_W-1:0])
                RLVD_CTRL_OFS: begin
                    next_s.rdata[7:0] = ctrl_rd;
                end
                RLVD_STAT_OFS: begin
                    next_s.rdata[7:0] = stat_rd;
                    if (s.fall_flag) next_s.fall_seen = 1'b1;
                    if (s.rise_flag) next_s.rise_seen = 1'b1;
                end
                RLVD_RSTS_OFS: begin
                    next_s.rdata[RLVD_SYSRST_BIT] = s.sys_reset_n;
                    next_s.rdata[RLVD_VRST_BIT]   = s.volt_reset_n;
                end
                default: begin
                    next_s.rresp = RLVD_RESP_SLVERR;
                end
            endcase
        end

        // Watchdog reinitialises the control bits, low-voltage reset never does
        if (wdt_reset) begin
            next_s.power_on  = RLVD_CTRL_RST[RLVD_PWR_BIT];
            next_s.level_sel = RLVD_CTRL_RST[RLVD_SEL_BIT];
            next_s.reset_en  = RLVD_CTRL_RST[RLVD_RSTEN_BIT];
            next_s.fall_en   = RLVD_CTRL_RST[RLVD_FALLEN_BIT];
            next_s.rise_en   = RLVD_CTRL_RST[RLVD_RISEEN_BIT];
        end

        // Detection events come after software clears, so a set wins
        next_s.prev_warn = cmp_s.below_warn;
        next_s.prev_rise = cmp_s.above_rise;
        if (!s.power_on) begin
            next_s.volt_warn_n  = 1'b1;
            next_s.volt_reset_n = 1'b1;
            next_s.armed        = 1'b0;
        end else begin
            next_s.volt_reset_n = !lv_trip;
            if (cmp_s.below_warn && !s.prev_warn) begin
                next_s.volt_warn_n = 1'b0;
                next_s.fall_flag   = 1'b1;
                next_s.armed       = 1'b1;
                next_s.irq         = s.fall_en;
            end
            if (cmp_s.above_rise && !s.prev_rise && s.armed && !cmp_s.below_reset) begin
                next_s.volt_warn_n = 1'b1;
                next_s.armed       = 1'b0;
                if (s.rise_en) begin
                    next_s.rise_flag = 1'b1;
                    next_s.irq       = 1'b1;
                end
            end
            if (cmp_s.below_reset) begin
                next_s.armed = 1'b0;
            end
        end
        // Flags belong to the low-voltage reset domain
        if (lv_trip) begin
            next_s.fall_flag = 1'b0;
            next_s.rise_flag = 1'b0;
            next_s.fall_seen = 1'b0;
            next_s.rise_seen = 1'b0;
        end

        // Reset-delay prescaler
        if (!pin_filt || lv_trip) begin
            next_s.phase       = RLVD_PH_HOLD;
            next_s.count       = '0;
            next_s.sys_reset_n = 1'b0;
        end else begin
            unique case (s.phase)
                RLVD_PH_HOLD: begin
                    next_s.phase = RLVD_PH_COUNT;
                    next_s.count = '0;
                end
                RLVD_PH_COUNT: begin
                    if (s.count == RLVD_CNT_W'(DELAY_CYCLES - 1)) begin
                        next_s.phase       = RLVD_PH_RUN;
                        next_s.sys_reset_n = 1'b1;
                        next_s.done        = 1'b1;
                    end else begin
                        next_s.count = s.count + RLVD_CNT_W'(1);
                    end
                end
                RLVD_PH_RUN: begin
                end
            endcase
        end

        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready  = !next_s.w_full && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    assign sys_reset_n        = s.sys_reset_n;
    assign delay_count_done   = s.done;
    assign volt_reset_n       = s.volt_reset_n;
    assign volt_warn_n        = s.volt_warn_n;
    assign external_irq_line0 = s.irq;
    assign detector_power_on  = s.power_on;
    assign reset_level_select = s.level_sel;
    assign s_axi_awready      = s.awready;
    assign s_axi_wready       = s.wready;
    assign s_axi_bvalid       = s.bvalid;
    assign s_axi_bresp        = s.bresp;
    assign s_axi_arready      = s.arready;
    assign s_axi_rvalid       = s.rvalid;
    assign s_axi_rdata        = s.rdata;
    assign s_axi_rresp        = s.rresp;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence pin_short_low;
        (pin_filt && ext_reset_pin_n) ##1 !ext_reset_pin_n [*8] ##1 !ext_reset_pin_n ##1 ext_reset_pin_n;
    endsequence

    sequence trip_seen;
        s.power_on && s.reset_en && cmp_s.below_reset;
    endsequence

    pin_hold_a: assert property (!pin_filt |=> !sys_reset_n && s.phase == RLVD_PH_HOLD)
        else $error("chip left reset while pin held low");
    release_count_a: assert property ($rose(sys_reset_n) |-> $past(s.count) == DELAY_CYCLES - 1)
        else $error("internal reset released at wrong count");
    release_done_a: assert property ($rose(sys_reset_n) |-> delay_count_done && $past(s.phase) == RLVD_PH_COUNT)
        else $error("release without prescaler overflow");
    pin_glitch_a: assert property (pin_short_low |-> pin_filt [*8])
        else $error("short reset pin pulse passed the filter");
    unit_standby_a: assert property (!s.power_on |=> volt_reset_n && volt_warn_n)
        else $error("detector active while powered off");
    lv_reset_a: assert property (trip_seen |=> !volt_reset_n && !sys_reset_n && s.count == 0)
        else $error("low-voltage reset not applied");
    ctrl_keep_a: assert property (!volt_reset_n && !wdt_reset && !wr_ctrl |=> $stable(ctrl_rd))
        else $error("control bits changed by low-voltage reset");
    wdt_init_a: assert property (wdt_reset |=> ctrl_rd == RLVD_CTRL_RST)
        else $error("watchdog did not reinitialise control");
    fall_event_a: assert property (s.power_on && cmp_s.below_warn && !s.prev_warn && !lv_trip
        |=> s.fall_flag && !volt_warn_n && external_irq_line0 == $past(s.fall_en))
        else $error("fall event mishandled");
    rise_event_a: assert property (s.power_on && s.armed && cmp_s.above_rise && !s.prev_rise
        && !cmp_s.below_reset && !lv_trip |=> volt_warn_n && s.rise_flag == ($past(s.rise_en) || $past(s.rise_flag)))
        else $error("rise event mishandled");
    flag_hold_a: assert property (s.fall_flag && !s.fall_seen && !lv_trip |=> s.fall_flag)
        else $error("fall flag cleared without prior read");
endmodule // rlvd_top

// *** rlvd_pkg.sv ***
// Purpose: Shared constants and types of the reset release and low-voltage detect block
// Assumes: 100 MHz ref_clk, AXI4-Lite register access with 32-bit data
// Notes:   Registers hold their bits in the low byte; upper bits read as zero
package rlvd_pkg;

    localparam int unsigned RLVD_CLK_MHZ      = 100;
    localparam int unsigned RLVD_DELAY_CYCLES = 131072;
    localparam int unsigned RLVD_CNT_W        = 18;
    // Glitch filter on the reset pin, least time rounds up
    localparam int unsigned RLVD_FILT_NS      = 100;
    localparam int unsigned RLVD_FILT_CYC     = (RLVD_FILT_NS * RLVD_CLK_MHZ + 999) / 1000;
    localparam int unsigned RLVD_FILT_W       = 4;

    localparam int unsigned RLVD_ADDR_W       = 4;
    localparam logic [3:0]  RLVD_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  RLVD_STAT_OFS     = 4'h4;
    localparam logic [3:0]  RLVD_RSTS_OFS     = 4'h8;

    // detect_control_reg fields
    localparam int unsigned RLVD_PWR_BIT      = 7;
    localparam int unsigned RLVD_SEL_BIT      = 3;
    localparam int unsigned RLVD_RSTEN_BIT    = 2;
    localparam int unsigned RLVD_FALLEN_BIT   = 1;
    localparam int unsigned RLVD_RISEEN_BIT   = 0;
    localparam logic [7:0]  RLVD_CTRL_RST     = 8'h00;
    // detect_status_reg fields, bits 7..2 always read as one
    localparam int unsigned RLVD_FALL_BIT     = 1;
    localparam int unsigned RLVD_RISE_BIT     = 0;
    localparam logic [7:0]  RLVD_STAT_RSVD    = 8'hFC;
    // Reset status register fields
    localparam int unsigned RLVD_SYSRST_BIT   = 1;
    localparam int unsigned RLVD_VRST_BIT     = 0;

    localparam logic [1:0]  RLVD_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RLVD_RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic below_reset;
        logic below_warn;
        logic above_rise;
    } rlvd_cmp_t;

    typedef enum logic [2:0] {
        RLVD_PH_HOLD  = 3'b001,
        RLVD_PH_COUNT = 3'b010,
        RLVD_PH_RUN   = 3'b100
    } rlvd_phase_t;

endpackage

// *** rlvd_sync.sv ***
// Purpose: Two-stage synchroniser for the comparator outputs
// Assumes: Inputs may change at any time
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module rlvd_sync import rlvd_pkg::*; (
    input  wire logic      ref_clk,
    input  wire logic      rst_n,
    input  wire rlvd_cmp_t async_in,
    output rlvd_cmp_t      sync_out
);
    typedef struct packed {
        rlvd_cmp_t meta;
        rlvd_cmp_t stab;
    } rlvd_sync_st_t;

    rlvd_sync_st_t s;
    rlvd_sync_st_t next_s;

    always_comb begin
        next_s      = s;
        next_s.meta = async_in;
        next_s.stab = s.meta;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stab;
endmodule // rlvd_sync

// *** rlvd_filter.sv ***
// Purpose: Noise filter on the external reset pin
// Assumes: Pin sampled synchronously to ref_clk
// Notes:   Level must hold RLVD_FILT_CYC cycles before it is passed on
`timescale 1ns/1ns
module rlvd_filter import rlvd_pkg::*; (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic raw_n,
    output logic      filt_n
);
    typedef struct packed {
        logic [RLVD_FILT_W-1:0] cnt;
        logic                   filt;
    } rlvd_filt_st_t;

    rlvd_filt_st_t s;
    rlvd_filt_st_t next_s;

    always_comb begin
        next_s = s;
        if (raw_n == s.filt) begin
            next_s.cnt = '0;
        end else if (s.cnt == RLVD_FILT_W'(RLVD_FILT_CYC - 1)) begin
            next_s.filt = raw_n;
            next_s.cnt  = '0;
        end else begin
            next_s.cnt = s.cnt + RLVD_FILT_W'(1);
        end
    end

    // Starts in reset: the pin counts as low until proven high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign filt_n = s.filt;
endmodule // rlvd_filter

// *** rlvd_partner.sv ***
// Purpose: Behavioural model of the analog supply comparators
// Assumes: Supply given in millivolts; comparators run even while unpowered
// Notes:   Levels are plain defaults; the block must ignore them in standby
`timescale 1ns/1ns
module rlvd_partner import rlvd_pkg::*; #(
    parameter int unsigned RST_LO_MV = 2300,
    parameter int unsigned RST_HI_MV = 3600,
    parameter int unsigned FALL_MV   = 3700,
    parameter int unsigned RISE_MV   = 4000
) (
    input  wire logic [15:0] vcc_mv,
    input  wire logic        level_sel,
    output rlvd_cmp_t        cmp
);
    always_comb begin
        cmp.below_reset = vcc_mv < (level_sel ? RST_HI_MV : RST_LO_MV);
        cmp.below_warn  = vcc_mv < FALL_MV;
        cmp.above_rise  = vcc_mv > RISE_MV;
    end
endmodule // rlvd_partner

// *** rlvd_test.sv ***
// Purpose: Self-checking bench of the reset release and low-voltage detect block
// Assumes: Shortened prescaler count so each release takes a few dozen cycles
// Notes:   Release counts are checked in a window, filter and sync add slack
`timescale 1ns/1ns
module rlvd_test import rlvd_pkg::*;;
    localparam int unsigned DLY = 16;
    typedef struct packed {logic wr; logic [3:0] a; logic [7:0] d; logic [1:0] resp;} rlvd_row_t;
    logic        ref_clk = 0, rst_n = 0, ext_reset_pin_n = 1, wdt_reset = 0;
    logic [15:0] vcc_mv = 16'h1388;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic        sys_reset_n, delay_count_done, volt_reset_n, volt_warn_n;
    logic        external_irq_line0, detector_power_on, reset_level_select;
    rlvd_cmp_t   cmp;
    int          fails = 0, n_tests = 0, n_irq = 0;
    rlvd_row_t   rows [9] = '{'{0, 4'h8, 8'h03, 2'h0}, '{0, 4'h0, 8'h00, 2'h0}, '{0, 4'h4, 8'hFC, 2'h0},
        '{1, 4'h0, 8'h80, 2'h0}, '{0, 4'h0, 8'h80, 2'h0}, '{1, 4'hC, 8'hFF, 2'h2},
        '{0, 4'hC, 8'h00, 2'h2}, '{1, 4'h4, 8'hFF, 2'h0}, '{0, 4'h4, 8'hFC, 2'h0}};

    rlvd_top #(.DELAY_CYCLES(DLY)) dut (.ref_clk, .rst_n, .ext_reset_pin_n, .wdt_reset,
        .cmp_async(cmp), .sys_reset_n, .delay_count_done, .volt_reset_n, .volt_warn_n,
        .external_irq_line0, .detector_power_on, .reset_level_select, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    rlvd_partner ana (.vcc_mv(vcc_mv), .level_sel(reset_level_select), .cmp(cmp));

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (external_irq_line0 === 1'b1) n_irq <= n_irq + 1;

    task automatic complete_run();
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] rr);
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_awaddr  <= {28'h0, a};
        s_axi_wdata   <= {24'h0, v};
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] rd, output logic [1:0] rr);
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= {28'h0, a};
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        axi_wr(a, v, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        axi_rd(a, d, r);
        chk("rdata", {24'h0, e}, d);
        chk("rresp", 32'h0, {30'h0, r});
    endtask
    task automatic supply(input logic [15:0] v);
        @(posedge ref_clk);
        vcc_mv <= v;
    endtask
    task automatic wait_rel(input int lo, input int hi);
        int c;
        c = 0;
        while (sys_reset_n !== 1'b1 && c < hi + 5) begin
            @(negedge ref_clk);
            c++;
        end
        chk("release count", 32'h1, {31'h0, c >= lo && c <= hi});
        chk("count done pulse", 32'h1, {31'h0, delay_count_done});
    endtask

    initial begin
        #400000;
        fails++;
        complete_run();
    end

    initial begin
        cyc(5);
        chk("reset sys", 32'h0, {31'h0, sys_reset_n});
        chk("reset volt", 32'h1, {31'h0, volt_reset_n});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_rel(DLY + 10, DLY + 14);
        supply(16'h07D0);
        cyc(6);
        chk("standby reset", 32'h1, {31'h0, volt_reset_n});
        chk("standby warn", 32'h1, {31'h0, volt_warn_n});
        supply(16'h1388);
        foreach (rows[i]) begin
            if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, r);
            else axi_rd(rows[i].a, d, r);
            if (!rows[i].wr) chk("row rdata", {24'h0, rows[i].d}, d);
            chk("row resp", {30'h0, rows[i].resp}, {30'h0, r});
        end
        cyc(5000);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h83); // port setup would follow outside this block
        supply(16'h0DAC);
        cyc(1);
        chk("warn synced", 32'h1, {31'h0, volt_warn_n});
        cyc(4);
        chk("warn low", 32'h0, {31'h0, volt_warn_n});
        chk("fall irq", 32'h1, n_irq);
        wr(4'h4, 8'h00);
        rchk(4'h4, 8'hFE);
        supply(16'h1194);
        cyc(5);
        chk("warn high", 32'h1, {31'h0, volt_warn_n});
        chk("rise irq", 32'h2, n_irq);
        rchk(4'h4, 8'hFF);
        wr(4'h4, 8'h00);
        rchk(4'h4, 8'hFC);
        wr(4'h0, 8'h80);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h80);
        cyc(5000);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h8C);
        supply(16'h0BB8);
        cyc(5);
        chk("volt reset low", 32'h0, {31'h0, volt_reset_n});
        chk("chip held", 32'h0, {31'h0, sys_reset_n});
        chk("no fall irq", 32'h2, n_irq);
        supply(16'h1388);
        cyc(1);
        wait_rel(DLY + 1, DLY + 8);
        rchk(4'h0, 8'h8C);
        chk("power level out", 32'h3, {30'h0, detector_power_on, reset_level_select});
        wr(4'h0, 8'h88);
        rchk(4'h0, 8'h88);
        @(posedge ref_clk);
        wdt_reset <= 1'b1;
        @(posedge ref_clk);
        wdt_reset <= 1'b0;
        rchk(4'h0, 8'h00);
        chk("power level init", 32'h0, {30'h0, detector_power_on, reset_level_select});
        // Longest pulse the filter must still reject: nine samples low
        @(posedge ref_clk);
        ext_reset_pin_n <= 1'b0;
        repeat (9) @(posedge ref_clk);
        ext_reset_pin_n <= 1'b1;
        repeat (15) begin
            cyc(1);
            chk("short pulse", 32'h1, {31'h0, sys_reset_n});
        end
        @(posedge ref_clk);
        ext_reset_pin_n <= 1'b0;
        cyc(14);
        chk("pin holds reset", 32'h0, {31'h0, sys_reset_n});
        @(posedge ref_clk);
        ext_reset_pin_n <= 1'b1;
        wait_rel(DLY + 10, DLY + 14);
        complete_run();
    end
endmodule // rlvd_test
